// ### rtl/flkp_pkg.sv
// Purpose: Shared constants and types for the flash block lock and power-on block
// Assumes: 100 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes: Offsets are byte addresses; each register is one aligned word
package flkp_pkg;
    // Block array shape
    localparam int NUM_BLOCKS = 131;
    localparam int BLK_W = 8;
    // Clock rate and default settling time before ready release
    localparam int CLK_MHZ = 100;
    localparam int RWL_US_DEFAULT = 100;
    localparam int CNT_W = 16;
    // Register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_BLKSEL = 8'h04;
    localparam logic [7:0] OFS_BLKSTAT = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    // Command register fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BLK_LSB = 8;
    localparam logic [1:0] OP_LOCK = 2'h1;
    localparam logic [1:0] OP_UNLOCK = 2'h2;
    localparam logic [1:0] OP_LDOWN = 2'h3;
    // Block status fields
    localparam int BS_LOCK = 0;
    localparam int BS_LDN = 1;
    localparam int BS_WP = 2;
    // Status register fields
    localparam int ST_PE_ERR = 0;
    localparam int ST_REJ = 1;
    localparam int ST_READY = 2;
    localparam int ST_WP = 3;
    localparam int ST_PSUSP = 4;
    localparam int ST_ESUSP = 5;
    // Synchroniser bit positions
    localparam int SY_WP = 4;
    localparam int SY_RP = 3;
    localparam int SY_VDD = 2;
    localparam int SY_VDDO = 1;
    localparam int SY_DROP = 0;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Power-on sequence, Gray coded along hold, settle, ready
    typedef enum logic [1:0] {
        PWR_HOLD = 2'h0,
        PWR_SETTLE = 2'h1,
        PWR_READY = 2'h3
    } flkp_pwr_type;
endpackage

// ### rtl/flkp_top.sv
// Purpose: Per-block lock, lock-down and write-protect logic plus ready release
// Assumes: PE_* and suspend inputs come from logic on CLK_SYS; pins are asynchronous
// Notes: Commands arrive through the CMD register; status through BLKSTAT and STATUS
// Notes on behaviour
// - Any reset or power loss locks every block
// - Program/erase on locked block refused, error flagged
// - Program/erase allowed only on unlocked blocks
// - Lock command sets the block lock bit
// - Unlock clears lock bit unless locked-down
// - Lock-down sets lock-down and lock bits
// - Locked-down blocks protected like locked blocks
// - Protect low: lock changes ignored on locked-down
// - Protect high: locked-down blocks may be unlocked
// - Protect high: locked-down blocks freely lock/unlock
// - Protect falling: locked-down blocks relock
// - Protect rising: restore saved lock bit
// - Status reads protect level, lock-down, lock
// - Lock during erase suspend applies at once
// - Locking rejected while program suspended
// - Ready low during power-on and reset
// - Ready released after settling delay
// - Supply drop resets, ready held low
// - Software never clears the lock-down bit
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module flkp_top #(
    parameter int RWL_US = flkp_pkg::RWL_US_DEFAULT
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic WP_N,
    input wire logic HW_RESET_N,
    input wire logic VDD_POR_OK,
    input wire logic VDDO_POR_OK,
    input wire logic SUPPLY_DROP,
    input wire logic PE_REQ,
    input wire logic [7:0] PE_BLOCK,
    output logic PE_OK,
    input wire logic PROG_SUSPENDED,
    input wire logic ERASE_SUSPENDED,
    output logic CFG_READY
);
    localparam int NB = flkp_pkg::NUM_BLOCKS;
    // Settling time is a least time, so the integer product already rounds up
    localparam int RWL_CYC = RWL_US * flkp_pkg::CLK_MHZ;
    localparam logic [flkp_pkg::CNT_W-1:0] RWL_LAST = flkp_pkg::CNT_W'(RWL_CYC - 1);

    typedef struct packed {
        logic [NB-1:0] lock;
        logic [NB-1:0] ldn;
        logic [NB-1:0] saved;
        logic [4:0] s1;
        logic [4:0] s2;
        logic wp_prev;
        flkp_pkg::flkp_pwr_type pstate;
        logic [flkp_pkg::CNT_W-1:0] cnt;
        logic ready;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] blksel;
        logic pe_err;
        logic rej;
    } flkp_state_type;

    flkp_state_type q;
    flkp_state_type d;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic blk_valid(input logic [7:0] b);
        blk_valid = (b < 8'(NB));
    endfunction

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        reg_hit = (a[7:2] == ofs[7:2]);
    endfunction

    logic wp;
    logic dev_rst;
    logic wr_go;
    logic cmd_go;
    logic [1:0] cmd_op;
    logic [7:0] cmd_blk;
    logic cmd_ok;
    logic pe_block_valid;

    // Synchronised pin levels; the first stage is only copied into the second
    assign wp = q.s2[flkp_pkg::SY_WP];
    assign dev_rst = ~q.s2[flkp_pkg::SY_RP] | ~q.s2[flkp_pkg::SY_VDD]
        | ~q.s2[flkp_pkg::SY_VDDO] | q.s2[flkp_pkg::SY_DROP];
    assign wr_go = q.aw_got & q.w_got & ~q.bvalid;
    assign cmd_go = wr_go & reg_hit(q.awaddr, flkp_pkg::OFS_CMD) & (&q.wstrb[1:0]);
    assign cmd_op = q.wdata[flkp_pkg::CMD_OP_LSB +: 2];
    assign cmd_blk = q.wdata[flkp_pkg::CMD_BLK_LSB +: 8];
    assign cmd_ok = cmd_go & (cmd_op != 2'h0) & blk_valid(cmd_blk) & ~PROG_SUSPENDED & ~dev_rst;
    assign pe_block_valid = blk_valid(PE_BLOCK);

    // lock-down forces lock bit, so it protects too
    assign PE_OK = PE_REQ & pe_block_valid & ~dev_rst & ~q.lock[PE_BLOCK];

    // Bus handshakes are combinational from state flops
    assign AWREADY = ~q.aw_got & ~q.bvalid;
    assign WREADY = ~q.w_got & ~q.bvalid;
    assign BVALID = q.bvalid;
    assign BRESP = q.bresp;
    assign ARREADY = ~q.rvalid;
    assign RVALID = q.rvalid;
    assign RDATA = q.rdata;
    assign RRESP = q.rresp;
    assign CFG_READY = q.ready;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic mapped;
        logic [31:0] rd;
        logic pe_set;
        logic rej_set;
        logic [1:0] clr;
        mapped = 1'b0;
        rd = 32'h0;
        pe_set = 1'b0;
        rej_set = 1'b0;
        clr = 2'h0;
        d = q;

        // Two-flop synchronisers on all pins
        d.s1 = {WP_N, HW_RESET_N, VDD_POR_OK, VDDO_POR_OK, SUPPLY_DROP};
        d.s2 = q.s1;
        d.wp_prev = wp;

        // Block protection state
        if (dev_rst) begin
            d.lock = '1;
            d.ldn = '0;
            d.saved = '1;
        end else begin
            if (wp && !q.wp_prev) begin
                d.lock = (q.lock & ~q.ldn) | (q.saved & q.ldn);
            end
            if (!wp && q.wp_prev) begin
                d.saved = (q.saved & ~q.ldn) | (q.lock & q.ldn);
                d.lock = q.lock | q.ldn;
            end
            if (cmd_ok) begin
                unique case (cmd_op)
                    flkp_pkg::OP_LOCK: begin
                        if (wp || !q.ldn[cmd_blk]) begin
                            d.lock[cmd_blk] = 1'b1;
                        end
                    end
                    flkp_pkg::OP_UNLOCK: begin
                        if (wp || !q.ldn[cmd_blk]) begin
                            d.lock[cmd_blk] = 1'b0;
                        end
                    end
                    flkp_pkg::OP_LDOWN: begin
                        if (!q.ldn[cmd_blk]) begin
                            d.saved[cmd_blk] = d.lock[cmd_blk];
                        end
                        d.ldn[cmd_blk] = 1'b1;
                        d.lock[cmd_blk] = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end

        pe_set = PE_REQ & ~PE_OK;
        rej_set = cmd_go & ~cmd_ok;

        // Power-on sequence
        if (dev_rst) begin
            d.pstate = flkp_pkg::PWR_HOLD;
            d.cnt = '0;
        end else begin
            unique case (q.pstate)
                flkp_pkg::PWR_HOLD: begin
                    d.pstate = flkp_pkg::PWR_SETTLE;
                    d.cnt = '0;
                end
                flkp_pkg::PWR_SETTLE: begin
                    if (q.cnt == RWL_LAST) begin
                        d.pstate = flkp_pkg::PWR_READY;
                    end else begin
                        d.cnt = q.cnt + 1'b1;
                    end
                end
                flkp_pkg::PWR_READY: begin
                    d.pstate = flkp_pkg::PWR_READY;
                end
                default: begin
                    d.pstate = flkp_pkg::PWR_HOLD;
                end
            endcase
        end
        d.ready = (d.pstate == flkp_pkg::PWR_READY);

        // Write address and data taken in either order
        if (AWVALID && AWREADY) begin
            d.aw_got = 1'b1;
            d.awaddr = AWADDR;
        end
        if (WVALID && WREADY) begin
            d.w_got = 1'b1;
            d.wdata = WDATA;
            d.wstrb = WSTRB;
        end
        if (wr_go) begin
            mapped = reg_hit(q.awaddr, flkp_pkg::OFS_CMD)
                | reg_hit(q.awaddr, flkp_pkg::OFS_BLKSEL)
                | reg_hit(q.awaddr, flkp_pkg::OFS_BLKSTAT)
                | reg_hit(q.awaddr, flkp_pkg::OFS_STATUS);
            if (reg_hit(q.awaddr, flkp_pkg::OFS_BLKSEL) && q.wstrb[0]) begin
                d.blksel = q.wdata[7:0];
            end
            if (reg_hit(q.awaddr, flkp_pkg::OFS_STATUS) && q.wstrb[0]) begin
                clr = {q.wdata[flkp_pkg::ST_REJ], q.wdata[flkp_pkg::ST_PE_ERR]};
            end
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = mapped ? flkp_pkg::RESP_OKAY : flkp_pkg::RESP_SLVERR;
        end else if (q.bvalid && BREADY) begin
            d.bvalid = 1'b0;
        end

        // Sticky flags: write one clears, a new event in the same cycle wins
        d.pe_err = (q.pe_err & ~clr[0]) | pe_set;
        d.rej = (q.rej & ~clr[1]) | rej_set;

        // Read channel, data registered one cycle after address
        if (ARVALID && ARREADY) begin
            d.rvalid = 1'b1;
            d.rresp = flkp_pkg::RESP_OKAY;
            if (reg_hit(ARADDR, flkp_pkg::OFS_BLKSEL)) begin
                rd[7:0] = q.blksel;
            end else if (reg_hit(ARADDR, flkp_pkg::OFS_BLKSTAT)) begin
                rd[flkp_pkg::BS_WP] = wp;
                if (blk_valid(q.blksel)) begin
                    rd[flkp_pkg::BS_LDN] = q.ldn[q.blksel];
                    rd[flkp_pkg::BS_LOCK] = q.lock[q.blksel];
                end
            end else if (reg_hit(ARADDR, flkp_pkg::OFS_STATUS)) begin
                rd[flkp_pkg::ST_PE_ERR] = q.pe_err;
                rd[flkp_pkg::ST_REJ] = q.rej;
                rd[flkp_pkg::ST_READY] = q.ready;
                rd[flkp_pkg::ST_WP] = wp;
                rd[flkp_pkg::ST_PSUSP] = PROG_SUSPENDED;
                rd[flkp_pkg::ST_ESUSP] = ERASE_SUSPENDED;
            end else if (!reg_hit(ARADDR, flkp_pkg::OFS_CMD)) begin
                d.rresp = flkp_pkg::RESP_SLVERR;
            end
            d.rdata = rd;
        end else if (q.rvalid && RREADY) begin
            d.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    // Synchronous reset; every field takes a constant
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            q <= '0;
            q.lock <= '1;
            q.saved <= '1;
            q.s2[flkp_pkg::SY_DROP] <= 1'b1;
            q.pstate <= flkp_pkg::PWR_HOLD;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    reset_locks_all_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        dev_rst |=> (&q.lock) && (q.ldn == '0))
        else $error("blocks not all locked after reset");

    pe_refused_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (PE_REQ && pe_block_valid && q.lock[PE_BLOCK]) |-> !PE_OK ##1 q.pe_err)
        else $error("locked block program not refused");

    pe_allowed_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (PE_REQ && pe_block_valid && !dev_rst && !q.lock[PE_BLOCK]) |-> PE_OK)
        else $error("unlocked block program refused");

    ldown_sets_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (cmd_ok && cmd_op == flkp_pkg::OP_LDOWN)
        |=> q.ldn[$past(cmd_blk)] && q.lock[$past(cmd_blk)])
        else $error("lock-down did not set both bits");

    unlock_ignored_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (cmd_ok && cmd_op == flkp_pkg::OP_UNLOCK && !wp && !q.wp_prev
            && q.ldn[cmd_blk]) |=> q.lock[$past(cmd_blk)])
        else $error("locked-down block unlocked while protected");

    relock_fall_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (!dev_rst && !wp && q.wp_prev) |=> ((q.lock & $past(q.ldn)) == $past(q.ldn)))
        else $error("locked-down block not relocked");

    susp_reject_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (cmd_go && PROG_SUSPENDED && !dev_rst) |=> q.rej && $stable(q.ldn))
        else $error("lock command accepted in program suspend");

    ready_low_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        dev_rst |=> !CFG_READY)
        else $error("ready high during reset");

    ready_delay_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $rose(CFG_READY) |-> $past(q.pstate) == flkp_pkg::PWR_SETTLE && $past(q.cnt) == RWL_LAST)
        else $error("ready released before settling delay");

    drop_holds_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        q.s2[flkp_pkg::SY_DROP] |=> !CFG_READY ##1 !CFG_READY)
        else $error("ready high after supply drop");

    ldn_sticky_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !dev_rst |=> ((q.ldn & $past(q.ldn)) == $past(q.ldn)))
        else $error("lock-down bit cleared without reset");

endmodule
`default_nettype wire

// ### tb/flkp_susp_model.sv
// Purpose: Program and erase engine on the far side, reporting its suspend state
// Assumes: Suspend requests are levels on the system clock
// Notes: LAT models an engine that takes a while to reach its suspend point
`timescale 1ns/100ps
`default_nettype none
module flkp_susp_model #(
    parameter int LAT = 3
) (
    input wire logic clk_sys,
    input wire logic esusp_req,
    input wire logic psusp_req,
    output var logic erase_suspended,
    output var logic prog_suspended
);
    int cnt = 0;
    ////////////////////////////////////////////////////////////////////////////
    // Known levels before the first edge
    initial begin
        erase_suspended = 1'h0;
        prog_suspended = 1'h0;
    end
    // Erase suspends late, resumes at once; program suspends next edge
    always @(posedge clk_sys) begin
        cnt <= esusp_req ? ((cnt < LAT) ? cnt + 1 : cnt) : 0;
        erase_suspended <= esusp_req && (cnt == LAT);
        prog_suspended <= psusp_req;
    end
endmodule
`default_nettype wire

// ### tb/flash_block_lock_and_por_test.sv
// Purpose: Self-checking bench for the block lock and ready release logic
// Assumes: Settling parameter cut to 1 us, so ready comes about 100 cycles late
// Notes: Ready inputs of the response channels stay high, the slave paces itself
`timescale 1ns/100ps
`default_nettype none
module flash_block_lock_and_por_test;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [7:0] pe_block = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1, arvalid = 1'h0, rready = 1'h1;
    logic wp_n = 1'h0, hw_reset_n = 1'h1, vdd_ok = 1'h1, vddo_ok = 1'h1, drop = 1'h0;
    logic pe_req = 1'h0, esusp_req = 1'h0, psusp_req = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, pe_ok, esusp, psusp, cfg_ready;
    logic [1:0] bresp, rresp, resp_q;
    logic [31:0] rdata, rd_q;
    int err_count = 0;
    int checks_done = 0;
    ////////////////////////////////////////////////////////////////////////////
    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;
    flkp_top #(.RWL_US(1)) DUT (.CLK_SYS(clk_sys), .RST_N(rst_n), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
        .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .WP_N(wp_n),
        .HW_RESET_N(hw_reset_n), .VDD_POR_OK(vdd_ok), .VDDO_POR_OK(vddo_ok),
        .SUPPLY_DROP(drop), .PE_REQ(pe_req), .PE_BLOCK(pe_block), .PE_OK(pe_ok),
        .PROG_SUSPENDED(psusp), .ERASE_SUSPENDED(esusp), .CFG_READY(cfg_ready));
    flkp_susp_model engine (.clk_sys(clk_sys), .esusp_req(esusp_req),
        .psusp_req(psusp_req), .erase_suspended(esusp), .prog_suspended(psusp));
    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task stop_test;
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Write: ready looked at mid-cycle, so the edge that takes it is known
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        // Start on a rising edge; a start at the falling edge misses a handshake
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        tb = 1'h0;
        for (int i = 0; i < 40 && !tb; i++) begin
            @(negedge clk_sys);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            resp_q = bresp;
            @(posedge clk_sys);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end
        chk(tb, 1'h1);
    endtask
    task rd(input logic [7:0] a);
        logic ta, tr;
        // Same rising-edge start as the write side
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'h1;
        tr = 1'h0;
        for (int i = 0; i < 40 && !tr; i++) begin
            @(negedge clk_sys);
            ta = arvalid & arready;
            tr = rvalid;
            rd_q = rdata;
            resp_q = rresp;
            @(posedge clk_sys);
            if (ta) arvalid <= 1'h0;
        end
        chk(tr, 1'h1);
    endtask
    task cmd(input logic [7:0] b, input logic [1:0] op);
        wr(flkp_pkg::OFS_CMD, {16'h0000, b, 6'h00, op});
    endtask
    // Triple read back as write-protect, lock-down, lock
    task bs(input logic [7:0] b, input logic [2:0] e);
        wr(flkp_pkg::OFS_BLKSEL, {24'h0, b});
        rd(flkp_pkg::OFS_BLKSTAT);
        chk(rd_q[2:0], e);
    endtask
    task st(input logic [31:0] m, input logic [31:0] e);
        rd(flkp_pkg::OFS_STATUS);
        chk(rd_q & m, e);
    endtask
    // Answer is combinational, so it is looked at in the request cycle
    task pe(input logic [7:0] b, input logic e);
        pe_block <= b;
        pe_req <= 1'h1;
        @(negedge clk_sys);
        chk(pe_ok, e);
        @(posedge clk_sys);
        pe_req <= 1'h0;
        @(posedge clk_sys);
    endtask
    // Bounded wait; too early or too late both fail
    task wait_ready;
        int n;
        n = 0;
        while (cfg_ready !== 1'h1 && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        chk(n >= 100 && n <= 110, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_boot;
        wait_ready; // settle delay
        bs(8'h00, 3'h1); // locked at start
        bs(8'h82, 3'h1); // last block locked
        rd(8'h10);
        chk(resp_q, flkp_pkg::RESP_SLVERR);
        chk(rd_q, 32'h0);
        wr(8'h14, 32'h1);
        chk(resp_q, flkp_pkg::RESP_SLVERR);
        // Out-of-range block and empty opcode are both refused and flagged
        cmd(8'h83, flkp_pkg::OP_LOCK);
        st(32'h2, 32'h2);
        wr(flkp_pkg::OFS_STATUS, 32'h2);
        cmd(8'h05, 2'h0);
        st(32'h2, 32'h2);
        wr(flkp_pkg::OFS_STATUS, 32'h2);
    endtask
    task t_lock;
        cmd(8'h05, flkp_pkg::OP_UNLOCK);
        bs(8'h05, 3'h0); // unlocked
        pe(8'h05, 1'h1); // allowed
        cmd(8'h05, flkp_pkg::OP_LOCK);
        bs(8'h05, 3'h1); // relocked
        // Command word with a partial strobe must not act
        wstrb <= 4'h1;
        cmd(8'h05, flkp_pkg::OP_UNLOCK);
        wstrb <= 4'hf;
        bs(8'h05, 3'h1); // partial command ignored
        pe(8'h05, 1'h0); // refused
        st(32'h1, 32'h1); // error flag
        wr(flkp_pkg::OFS_STATUS, 32'h1);
        st(32'h1, 32'h0);
    endtask
    task t_ldown;
        cmd(8'h06, flkp_pkg::OP_UNLOCK);
        cmd(8'h06, flkp_pkg::OP_LDOWN);
        bs(8'h06, 3'h3); // both bits set
        pe(8'h06, 1'h0); // protected
        cmd(8'h06, flkp_pkg::OP_UNLOCK);
        bs(8'h06, 3'h3); // unchanged
        st(32'h2, 32'h0);
    endtask
    task t_wp;
        wp_n <= 1'h1;
        repeat (4) @(posedge clk_sys);
        bs(8'h06, 3'h6); // saved lock back
        bs(8'h05, 3'h5); // level shown
        pe(8'h06, 1'h1); // writable
        cmd(8'h06, flkp_pkg::OP_LOCK);
        bs(8'h06, 3'h7); // lockable
        cmd(8'h06, flkp_pkg::OP_UNLOCK);
        bs(8'h06, 3'h6); // unlockable
        wp_n <= 1'h0;
        repeat (4) @(posedge clk_sys);
        bs(8'h06, 3'h3); // relocked down
    endtask
    task t_susp;
        esusp_req <= 1'h1;
        rd_q = 32'h0;
        for (int i = 0; i < 20 && rd_q[flkp_pkg::ST_ESUSP] !== 1'h1; i++) rd(flkp_pkg::OFS_STATUS);
        chk(rd_q[flkp_pkg::ST_ESUSP], 1'h1); // suspended first
        cmd(8'h07, flkp_pkg::OP_LDOWN);
        bs(8'h07, 3'h3); // immediate
        // Block 7 was locked before lock-down, so protect high gives 111
        wp_n <= 1'h1;
        repeat (4) @(posedge clk_sys);
        bs(8'h07, 3'h7); // locked value restored
        wp_n <= 1'h0;
        repeat (4) @(posedge clk_sys);
        esusp_req <= 1'h0;
        psusp_req <= 1'h1;
        repeat (2) @(posedge clk_sys);
        cmd(8'h08, flkp_pkg::OP_UNLOCK);
        bs(8'h08, 3'h1); // no change
        st(32'h2, 32'h2); // reject flag
        wr(flkp_pkg::OFS_STATUS, 32'h2);
        psusp_req <= 1'h0;
    endtask
    // Pin reset clears lock-down, supply drop locks block 6; both pull ready low
    task t_reset;
        hw_reset_n <= 1'h0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(cfg_ready, 1'h0); // held low
        bs(8'h06, 3'h1); // back to locked
        hw_reset_n <= 1'h1;
        wait_ready; // settle again
        cmd(8'h06, flkp_pkg::OP_UNLOCK);
        bs(8'h06, 3'h0); // lock-down gone
        drop <= 1'h1;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(cfg_ready, 1'h0); // low on drop
        bs(8'h06, 3'h1); // locked on drop
        drop <= 1'h0;
        wait_ready; // back after recovery
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'h1;
        t_boot;
        t_lock;
        t_ldown;
        t_wp;
        t_susp;
        t_reset;
        stop_test;
    end
    // Watchdog, well past the expected several hundred cycles
    initial begin
        #100000;
        err_count++;
        stop_test;
    end
endmodule
`default_nettype wire
